/* hw/lrd_rotmask.sv */
// Purpose: Rotator and wrap-around mask generator.
// Assumes: Shift count is already a left count.
// Notes:   Combinational; the core registers the result.
`timescale 1ns/1ps
module lrd_rotmask (
  // Request and result
  lrd_rot_if.unit rif
);
  import lrd_pkg::*;

  lrd_word_t        rot_in;
  logic [127:0]     rot_wide;

  // Duplicated low word feeds the 32-bit mode
  assign rot_in   = rif.dup_word ? {rif.src[31:0], rif.src[31:0]} : rif.src;
  // Doubling the value turns the shift into a rotate with no barrel mux tree
  assign rot_wide = {rot_in, rot_in} << rif.amount;
  assign rif.rotated = rot_wide[127:64];

  // Ones from start through stop, wrapping past 63; never all zero
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      if (rif.mstart <= rif.mstop) begin
        rif.mask[63-i] = (6'(i) >= rif.mstart) && (6'(i) <= rif.mstop);
      end else begin
        rif.mask[63-i] = (6'(i) >= rif.mstart) || (6'(i) <= rif.mstop);
      end
    end
  end

endmodule : lrd_rotmask

/* hw/lrd_top.sv */
// Purpose: Logical tail group and rotate datapath of a 64-bit integer unit.
// Assumes: Operands arrive with op_valid; issue logic converts right rotates.
// Notes:   One registered result per valid request, no state between ops.
`timescale 1ns/1ps
`include "lrd_cfg.svh"
module lrd_top (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Request from issue logic
  input  wire logic             op_valid,
  input  wire lrd_pkg::lrd_op_e op_sel,
  input  wire logic             record_bit,
  input  wire logic             mode64,
  input  wire lrd_pkg::lrd_word_t src_reg,
  input  wire lrd_pkg::lrd_word_t second_src,
  input  wire lrd_pkg::lrd_word_t dest_old,
  // Rotate controls
  input  wire logic [5:0]       rot_amount,
  input  wire logic             rotate_dup_word,
  input  wire logic [5:0]       mask_start,
  input  wire logic [5:0]       mask_stop,
  // Exception flags in: sticky, excess, wrap
  input  wire logic [2:0]       fixed_point_exception_reg_in,
  // Result to register file
  output lrd_pkg::lrd_word_t    dest_reg,
  output logic                  dest_we,
  output logic [3:0]            first_condition_field,
  output logic                  condition_register_we,
  output logic [2:0]            fixed_point_exception_reg
);
  import lrd_pkg::*;

  lrd_rot_if rif ();

  lrd_word_t  next_result;
  logic [3:0] next_crf;
  lrd_word_t  cmp_val;
  logic       is_count;

  // Count of leading zeros from the MSB; the word-count caller pads to bound it
  function automatic logic [6:0] lead_zeros(input lrd_word_t v);
    logic [6:0] n;
    logic       seen;
    n    = 7'h00;
    seen = 1'b0;
    for (int i = 63; i >= 0; i--) begin
      if (!seen && !v[i]) begin
        n = n + 7'h01;
      end else begin
        seen = 1'b1;
      end
    end
    return n;
  endfunction : lead_zeros

  // Rotate unit requests; right rotates arrive already as left counts
  assign rif.amount   = rot_amount;
  assign rif.dup_word = rotate_dup_word;
  assign rif.src      = src_reg;
  assign rif.mstart   = mask_start;
  assign rif.mstop    = mask_stop;

  lrd_rotmask u_rotmask (
    .rif (rif.unit)
  );

  // Result selection per operation
  always_comb begin
    next_result = `LRD_RST_DATA;
    unique case (op_sel)
      LRD_OP_ORC: begin
        next_result = src_reg | ~second_src;
      end
      LRD_OP_EXT_B: begin
        next_result = {{56{src_reg[`LRD_BYTE_SIGN]}}, src_reg[7:0]};
      end
      LRD_OP_EXT_H: begin
        next_result = {{48{src_reg[`LRD_HALF_SIGN]}}, src_reg[15:0]};
      end
      LRD_OP_EXT_W: begin
        next_result = {{32{src_reg[`LRD_WORD_SIGN]}}, src_reg[31:0]};
      end
      LRD_OP_CLZ_W: begin
        // Padding with ones stops the count at 32
        next_result = {57'h0, lead_zeros({src_reg[31:0], 32'hFFFF_FFFF})};
      end
      LRD_OP_CLZ_D: begin
        next_result = {57'h0, lead_zeros(src_reg)};
      end
      LRD_OP_ROT_AND: begin
        next_result = rif.rotated & rif.mask;
      end
      LRD_OP_ROT_INS: begin
        // Destination keeps its bits where the mask is clear
        next_result = (rif.rotated & rif.mask) | (dest_old & ~rif.mask);
      end
    endcase
  end

  // Compare against zero at the active mode width
  assign cmp_val  = mode64 ? next_result
                           : {{32{next_result[31]}}, next_result[31:0]};
  assign is_count = (op_sel == LRD_OP_CLZ_W) || (op_sel == LRD_OP_CLZ_D);

  // Condition field from the final destination value
  always_comb begin
    next_crf = `LRD_RST_CRF;
    next_crf[`LRD_CF_NEG]   = cmp_val[63] && !is_count;
    next_crf[`LRD_CF_ZERO]  = (cmp_val == 64'h0000_0000_0000_0000);
    next_crf[`LRD_CF_POS]   = !next_crf[`LRD_CF_NEG] && !next_crf[`LRD_CF_ZERO];
    // Sticky overflow is copied, never altered here
    next_crf[`LRD_CF_SUMOV] = fixed_point_exception_reg_in[2];
  end

  // Destination result, registered once per request
  always_ff @(posedge clk) begin
    if (rst) begin
      dest_reg <= `LRD_RST_DATA;
      dest_we  <= 1'b0;
    end else begin
      dest_reg <= op_valid ? next_result : `LRD_RST_DATA;
      dest_we  <= op_valid;
    end
  end

  // Condition field written only by record forms
  always_ff @(posedge clk) begin
    if (rst) begin
      first_condition_field <= `LRD_RST_CRF;
      condition_register_we <= 1'b0;
    end else begin
      first_condition_field <= (op_valid && record_bit) ? next_crf : `LRD_RST_CRF;
      condition_register_we <= op_valid && record_bit;
    end
  end

  // Exception flags returned unchanged; no op in this group alters them
  always_ff @(posedge clk) begin
    if (rst) begin
      fixed_point_exception_reg <= `LRD_RST_FLAGS;
    end else begin
      fixed_point_exception_reg <= fixed_point_exception_reg_in;
    end
  end

endmodule : lrd_top

/* pkg/lrd_cfg.svh */
// Purpose: Constants for the logical and rotate datapath.
// Assumes: Bit numbers are little-endian vector indices unless noted.
// Notes:   Architectural bit k of a 64-bit value sits at index 63-k.
`ifndef LRD_CFG_SVH
`define LRD_CFG_SVH

// Datapath and field widths
`define LRD_XLEN         64
`define LRD_HALF         32
`define LRD_SHAMT_W      6
`define LRD_CNT_W        7
`define LRD_CRF_W        4

// Sign bit indices (architectural 56, 48, 32)
`define LRD_BYTE_SIGN    7
`define LRD_HALF_SIGN    15
`define LRD_WORD_SIGN    31

// Condition field bit positions, negative flag first
`define LRD_CF_NEG       3
`define LRD_CF_POS       2
`define LRD_CF_ZERO      1
`define LRD_CF_SUMOV     0

// Reset values
`define LRD_RST_DATA     64'h0000_0000_0000_0000
`define LRD_RST_CRF      4'h0
`define LRD_RST_FLAGS    3'h0

`endif

/* pkg/lrd_pkg.sv */
// Purpose: Types shared by the logical and rotate datapath.
// Assumes: Every operation code is legal.
// Notes:   Constants live in lrd_cfg.svh.
package lrd_pkg;

  // Operation selects from the issue logic
  typedef enum logic [2:0] {
    LRD_OP_ORC     = 3'b000,
    LRD_OP_EXT_B   = 3'b001,
    LRD_OP_EXT_H   = 3'b010,
    LRD_OP_EXT_W   = 3'b011,
    LRD_OP_CLZ_W   = 3'b100,
    LRD_OP_CLZ_D   = 3'b101,
    LRD_OP_ROT_AND = 3'b110,
    LRD_OP_ROT_INS = 3'b111
  } lrd_op_e;

  typedef logic [63:0] lrd_word_t;

endpackage : lrd_pkg

/* pkg/lrd_rot_if.sv */
// Purpose: Carries rotate requests and mask results between core and unit.
// Assumes: Purely combinational traffic.
// Notes:   Mask indices use architectural numbering, bit 0 is the MSB.
`timescale 1ns/1ps
interface lrd_rot_if;
  import lrd_pkg::*;
  logic [5:0] amount;
  logic       dup_word;
  lrd_word_t  src;
  logic [5:0] mstart;
  logic [5:0] mstop;
  lrd_word_t  rotated;
  lrd_word_t  mask;

  modport core (output amount, dup_word, src, mstart, mstop, input rotated, mask);
  modport unit (input amount, dup_word, src, mstart, mstop, output rotated, mask);
endinterface : lrd_rot_if

/* test/logical_rotate_datapath_test.sv */
// Purpose: Random self-checking bench against a behavioural model.
// Assumes: Right rotates go through the issue model.
// Notes:   Outputs compared at the falling edge, one cycle after issue.
`timescale 1ns/1ps
module logical_rotate_datapath_test;
  import lrd_pkg::*;
  logic clk = 0, rst = 1, req = 0, rec = 0, m64 = 0, dup = 0, we, cwe;
  lrd_op_e op = LRD_OP_ORC;
  lrd_word_t a = '0, b = '0, d = '0, q, ew = '0, v;
  logic [5:0] n = '0, amt, ms = '0, me = '0;
  logic [2:0] xi = '0, xo, ex = '0;
  logic [3:0] cf, ec = '0;
  logic [1:0] ewe = '0;
  logic [31:0] seed = 32'hFAD2, r;
  int err_count = 0, check_count = 0, cyc = 0;
  always #10 clk = ~clk;
  lrd_issue iss (.right_n(n), .dup(dup), .left_n(amt));
  lrd_top dut (.clk, .rst, .op_valid(req), .op_sel(op), .record_bit(rec), .mode64(m64),
    .src_reg(a), .second_src(b), .dest_old(d), .rot_amount(amt), .rotate_dup_word(dup),
    .mask_start(ms), .mask_stop(me), .fixed_point_exception_reg_in(xi), .dest_reg(q),
    .dest_we(we), .first_condition_field(cf), .condition_register_we(cwe),
    .fixed_point_exception_reg(xo));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Result of the current request, worked out bit by bit
  function automatic lrd_word_t model();
    lrd_word_t t, m;
    int z, w;
    t = dup ? {2{a[31:0]}} : a;
    t = (t >> n) | (t << (7'd64 - n));
    for (int k = 0; k < 64; k++) begin
      m[63-k] = ms <= me ? (k >= ms && k <= me) : (k >= ms || k <= me);
    end
    z = 0;
    w = op == LRD_OP_CLZ_W ? 32 : 64;
    case (op)
      LRD_OP_ORC: return a | ~b;
      LRD_OP_EXT_B: return {{56{a[7]}}, a[7:0]};
      LRD_OP_EXT_H: return {{48{a[15]}}, a[15:0]};
      LRD_OP_EXT_W: return {{32{a[31]}}, a[31:0]};
      LRD_OP_ROT_AND: return t & m;
      LRD_OP_ROT_INS: return (t & m) | (d & ~m);
      default: begin
        while (z < w && !a[w-1-z]) z++;
        return 64'(z);
      end
    endcase
  endfunction : model
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      final_report();
    end
  end
  // Random requests, checked against the model one cycle later
  initial begin
    repeat (12) @(posedge clk);
    rst <= 0;
    repeat (1200) begin
      @(posedge clk);
      r = rnd();
      req <= r[3:0] != 0;
      op <= lrd_op_e'(r[6:4]);
      rec <= r[7];
      m64 <= r[8];
      dup <= r[9];
      n <= r[9] ? {1'b0, r[14:10]} : r[15:10];
      ms <= r[21:16];
      me <= r[27:22];
      xi <= r[30:28];
      a <= ({rnd(), rnd()} >> r[15:10]) & {64{r[3:0] != 1}};
      b <= {rnd(), rnd()};
      d <= {rnd(), rnd()};
      @(negedge clk);
      check(q, ew);
      check(64'({we, cwe}), 64'(ewe));
      check(64'(cf), 64'(ec));
      check(64'(xo), 64'(ex));
      ew = req ? model() : '0;
      v = m64 ? ew : {{32{ew[31]}}, ew[31:0]};
      ec = (req && rec) ? {$signed(v) < 0, $signed(v) > 0, v == 0, xi[2]} : 4'h0;
      ewe = {req, req && rec};
      ex = xi;
    end
    final_report();
  end
endmodule : logical_rotate_datapath_test

/* test/lrd_issue.sv */
// Purpose: Issue-side model that turns right rotates into left counts.
// Assumes: Word rotates ask for right counts below 32.
// Notes:   Behavioural and combinational.
`timescale 1ns/1ps
module lrd_issue (
  // Right count and mode in, left count out
  input  wire logic [5:0] right_n,
  input  wire logic       dup,
  output logic      [5:0] left_n
);
  // A zero count wraps to a full turn, which leaves the value alone
  assign left_n = dup ? 6'h20 - right_n : 6'h00 - right_n;
endmodule : lrd_issue

/* test/lrd_top_sva.sv */
// Purpose: Port-level assertions for the datapath.
// Assumes: One clock, synchronous reset.
// Notes:   Ports grouped per line to keep the file short.
`timescale 1ns/1ps
module lrd_top_sva (
  // Inputs, with the dest_reg and fixed_point_exception_reg results
  input wire logic clk, rst, op_valid, record_bit, mode64, rotate_dup_word,
  input wire lrd_pkg::lrd_op_e op_sel,
  input wire lrd_pkg::lrd_word_t src_reg, second_src, dest_old, dest_reg,
  input wire logic [5:0] rot_amount, mask_start, mask_stop,
  input wire logic [2:0] fixed_point_exception_reg_in, fixed_point_exception_reg,
  // Results
  input wire logic dest_we, condition_register_we,
  input wire logic [3:0] first_condition_field
);
  import lrd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A taken request, and a taken record-form request
  sequence s_take; op_valid; endsequence
  sequence s_rec; op_valid && record_bit; endsequence
  chk_write_pulse: assert property (s_take |=> dest_we)
    else $error("no write pulse");
  chk_idle_quiet: assert property (!op_valid |=> !dest_we && dest_reg == '0)
    else $error("output without request");
  chk_record_write: assert property (s_rec |=> condition_register_we)
    else $error("record form without field write");
  chk_plain_keeps: assert property (op_valid && !record_bit |=> !condition_register_we)
    else $error("plain form wrote field");
  chk_orc_value: assert property (s_take ##0 op_sel == LRD_OP_ORC |=>
    dest_reg == ($past(src_reg) | ~$past(second_src))) else $error("or-inverted wrong");
  chk_byte_sign: assert property (op_valid && op_sel == LRD_OP_EXT_B |=>
    dest_reg == {{56{$past(src_reg[7])}}, $past(src_reg[7:0])}) else $error("byte ext wrong");
  chk_clz_nonneg: assert property (s_rec ##0 op_sel inside {LRD_OP_CLZ_W, LRD_OP_CLZ_D}
    |=> !first_condition_field[3]) else $error("count set negative");
  chk_clz_range: assert property (op_valid && op_sel == LRD_OP_CLZ_W |=> dest_reg <= 64'h20)
    else $error("word count out of range");
  chk_flags_pass: assert property (1 |=>
    fixed_point_exception_reg == $past(fixed_point_exception_reg_in)) else $error("flags changed");
  chk_dclz_range: assert property (op_valid && op_sel == LRD_OP_CLZ_D |=> dest_reg <= 64'h40)
    else $error("double word count out of range");
  chk_zero_flag: assert property (s_rec |=> first_condition_field[1] ==
    ($past(mode64) ? dest_reg == 64'h0 : dest_reg[31:0] == 32'h0))
    else $error("zero flag wrong");
  chk_neg_flag: assert property (s_rec ##0 !(op_sel inside {LRD_OP_CLZ_W, LRD_OP_CLZ_D}) |=>
    first_condition_field[3] == ($past(mode64) ? dest_reg[63] : dest_reg[31]))
    else $error("negative flag wrong");
endmodule : lrd_top_sva
bind lrd_top lrd_top_sva chk (.clk, .rst, .op_valid, .record_bit, .mode64, .rotate_dup_word,
  .op_sel, .src_reg, .second_src, .dest_old, .dest_reg, .rot_amount, .mask_start, .mask_stop,
  .fixed_point_exception_reg_in, .fixed_point_exception_reg, .dest_we, .condition_register_we,
  .first_condition_field);
